// [shared/flash_mode_pkg.sv]
package flash_mode_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_FREQ_MHZ      = 40;
	// power-on setup phase of the array, least time
	localparam int SETUP_TIME_NS     = 5000;
	localparam int SETUP_CYCLES      = (SETUP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	// return to read mode after a cpu reset starts, longest time
	localparam int CPU_RST_RETURN_NS = 2000;
	localparam int CPU_RST_CYCLES    = (CPU_RST_RETURN_NS * CLK_FREQ_MHZ) / 1000;
	// erase start window, least time
	localparam int ERASE_WINDOW_US   = 96;
	localparam int ERASE_WIN_CYCLES  = ERASE_WINDOW_US * CLK_FREQ_MHZ;
	localparam int CNT_W             = 12;

	// ************************************************************
	// address map (byte addresses on the bus)
	// ************************************************************
	localparam logic [19:0] REG_STATUS_ADDR = 20'h40000;
	localparam logic [19:0] REG_IRQ_ADDR    = 20'h40004;
	localparam logic [19:0] REG_PROT_ADDR   = 20'h40008;
	localparam logic [17:0] CMD_ADDR1       = 18'h15554;
	localparam logic [17:0] CMD_ADDR2       = 18'h0AAA8;

	// ************************************************************
	// command codes (low data byte)
	// ************************************************************
	localparam logic [7:0] CMD_UNLOCK1   = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
	localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0] CMD_ERASE     = 8'h80;
	localparam logic [7:0] CMD_ERASE_GO  = 8'h30;
	localparam logic [7:0] CMD_PROTECT   = 8'h60;
	localparam logic [7:0] CMD_PROT_SET  = 8'h01;
	localparam logic [7:0] CMD_PROT_CLR  = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
	localparam logic [7:0] CMD_RESUME    = 8'h30;
	localparam logic [7:0] CMD_READ_RST  = 8'hF0;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int ST_DATA_POLL  = 7;
	localparam int ST_TOGGLE1    = 6;
	localparam int ST_FAILURE    = 5;
	localparam int ST_ERASE_WIN  = 3;
	localparam int ST_TOGGLE2    = 2;
	localparam int IRQ_REQ_BIT   = 0;
	localparam int IRQ_EN_BIT    = 1;
	localparam int IRQ_RB_BIT    = 2;
	localparam int PROT_ALL_BIT  = 4;
	localparam int PROT_READ_BIT = 5;
	localparam logic [5:0] PROT_RESET = 6'h00;

	// ************************************************************
	// state types
	// ************************************************************
	typedef enum logic [2:0] {
		SEQ_READ, SEQ_UNLOCK2, SEQ_CMD, SEQ_PROG_DATA,
		SEQ_ERASE_U1, SEQ_ERASE_U2, SEQ_ERASE_BLOCK, SEQ_PROT_BLOCK
	} seq_state_type;

	typedef enum logic [1:0] {
		EPC_IDLE, EPC_WINDOW, EPC_RUN
	} epc_state_type;

endpackage

// [shared/epc_if.sv]
`timescale 1ns/1ps
interface epc_if;
	logic start;
	logic op_erase;
	logic suspend;
	logic active;
	logic rb;
	logic window_open;
	logic suspended;
	logic done;
	logic fail;

	modport ctrl (output start, op_erase, suspend,
		input active, rb, window_open, suspended, done, fail);
	modport epc (input start, op_erase, suspend,
		output active, rb, window_open, suspended, done, fail);
endinterface

// [hdl/erase_program_controller.sv]
`timescale 1ns/1ps
module erase_program_controller (
	input  wire logic clk_i,
	input  wire logic rst_i,
	epc_if.epc        ep,
	input  wire logic arr_done_i,
	input  wire logic arr_fail_i,
	output logic      arr_prog_o,
	output logic      arr_erase_o
);

	flash_mode_pkg::epc_state_type state_reg;
	logic [flash_mode_pkg::CNT_W-1:0] win_cnt_reg;

	localparam int CNT_W = flash_mode_pkg::CNT_W;

	// ************************************************************
	// operation sequencing
	// ************************************************************
	// erase opens the window first (program starts at once), then array strobe held until the array reports done, erase strobe dropped while suspended
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg      <= flash_mode_pkg::EPC_IDLE;
			win_cnt_reg    <= '0;
			arr_prog_o     <= 1'b0;
			arr_erase_o    <= 1'b0;
			ep.window_open <= 1'b0;
			ep.suspended   <= 1'b0;
			ep.done        <= 1'b0;
			ep.fail        <= 1'b0;
		end else begin
			ep.done <= 1'b0;
			ep.fail <= 1'b0;
			case (state_reg)
				flash_mode_pkg::EPC_IDLE: begin
					if (ep.start) begin
						if (ep.op_erase) begin
							state_reg      <= flash_mode_pkg::EPC_WINDOW;
							ep.window_open <= 1'b1;
							win_cnt_reg    <= '0;
						end else begin
							state_reg  <= flash_mode_pkg::EPC_RUN;
							arr_prog_o <= 1'b1;
						end
					end
				end
				flash_mode_pkg::EPC_WINDOW: begin
					if (win_cnt_reg == CNT_W'(flash_mode_pkg::ERASE_WIN_CYCLES - 1)) begin
						ep.window_open <= 1'b0;
						state_reg      <= flash_mode_pkg::EPC_RUN;
						arr_erase_o    <= 1'b1;
					end else begin
						win_cnt_reg <= win_cnt_reg + 1'b1;
					end
				end
				flash_mode_pkg::EPC_RUN: begin
					if (arr_erase_o && ep.suspend) begin
						arr_erase_o  <= 1'b0;
						ep.suspended <= 1'b1;
					end else if (ep.suspended) begin
						if (!ep.suspend) begin
							arr_erase_o  <= 1'b1;
							ep.suspended <= 1'b0;
						end
					end else if (arr_done_i) begin
						arr_prog_o  <= 1'b0;
						arr_erase_o <= 1'b0;
						ep.done     <= 1'b1;
						ep.fail     <= arr_fail_i;
						state_reg   <= flash_mode_pkg::EPC_IDLE;
					end
				end
				default: state_reg <= flash_mode_pkg::EPC_IDLE;
			endcase
		end
	end

	// busy line high while an operation is active, erase window included, low when suspended
	assign ep.active = (state_reg != flash_mode_pkg::EPC_IDLE);
	assign ep.rb     = ep.active && !ep.suspended;

endmodule

// [hdl/flash_mode_ctrl.sv]
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module flash_mode_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [19:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        cpu_reset_i,
	input  wire logic        external_access_pin_i,
	input  wire logic [31:0] arr_rdata_i,
	input  wire logic        arr_done_i,
	input  wire logic        arr_fail_i,
	output logic      [15:0] arr_addr_o,
	output logic      [31:0] arr_wdata_o,
	output logic             arr_prog_o,
	output logic             arr_erase_o,
	output logic             ready_busy_o,
	output logic             irq_o,
	output logic             cpu_reset_hold_o
);

	// ************************************************************
	// declarations
	// ************************************************************
	epc_if ep ();

	flash_mode_pkg::seq_state_type seq_reg;
	logic        phase_reg;
	logic        por_done_reg;
	logic [flash_mode_pkg::CNT_W-1:0] por_cnt_reg;
	logic [flash_mode_pkg::CNT_W-1:0] crst_cnt_reg;
	logic        crst_hit;
	logic        start_reg;
	logic        op_erase_reg;
	logic        suspend_reg;
	logic [31:0] prog_data_reg;
	logic        fail_reg;
	logic        toggle1_reg;
	logic        toggle2_reg;
	logic        rb_prev_reg;
	logic        irq_req_reg;
	logic        irq_en_reg;
	logic [5:0]  prot_reg;
	logic        bus_take;
	logic        fire_wr;
	logic        fire_rd;
	logic        flash_hit;
	logic        status_mode;
	logic        wr_blocked;
	logic [7:0]  cmd;
	logic [7:0]  status_byte;
	logic [19:0] adr_word;

	localparam int CNT_W = flash_mode_pkg::CNT_W;

	// ************************************************************
	// decode helpers
	// ************************************************************
	// segment select from the top array address bits
	function automatic logic [1:0] segment_of(input logic [19:0] adr);
		segment_of = adr[17:16];
	endfunction

	function automatic logic in_flash(input logic [19:0] adr);
		in_flash = (adr[19:18] == 2'b00);
	endfunction

	// ************************************************************
	// erase-program controller
	// ************************************************************
	assign ep.start    = start_reg;
	assign ep.op_erase = op_erase_reg;
	assign ep.suspend  = suspend_reg;

	erase_program_controller u_epc (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ep          (ep.epc),
		.arr_done_i  (arr_done_i),
		.arr_fail_i  (arr_fail_i),
		.arr_prog_o  (arr_prog_o),
		.arr_erase_o (arr_erase_o)
	);

	// ************************************************************
	// bus handshake
	// ************************************************************
	// a request is taken once, answered on the following edge
	assign bus_take    = wb_cyc_i && wb_stb_i && !wb_ack_o && !phase_reg && por_done_reg;
	assign fire_wr     = phase_reg && wb_we_i;
	assign fire_rd     = phase_reg && !wb_we_i;
	assign adr_word    = {wb_adr_i[19:2], 2'b00};
	assign flash_hit   = in_flash(wb_adr_i);
	assign status_mode = ep.active || fail_reg;
	assign cmd         = wb_dat_i[7:0];
	assign wr_blocked  = prot_reg[flash_mode_pkg::PROT_ALL_BIT]
		|| prot_reg[segment_of(wb_adr_i)];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg <= 1'b0;
			wb_ack_o  <= 1'b0;
		end else begin
			phase_reg <= bus_take;
			wb_ack_o  <= phase_reg;
		end
	end

	// ************************************************************
	// power-on setup and cpu reset tracking
	// ************************************************************
	// array unreadable until setup count expires
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_cnt_reg  <= '0;
			por_done_reg <= 1'b0;
		end else if (!por_done_reg) begin
			if (por_cnt_reg == CNT_W'(flash_mode_pkg::SETUP_CYCLES - 1)) begin
				por_done_reg <= 1'b1;
			end else begin
				por_cnt_reg <= por_cnt_reg + 1'b1;
			end
		end
	end

	// hold the cpu while booting from flash during setup
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_reset_hold_o <= 1'b1;
		end else begin
			cpu_reset_hold_o <= external_access_pin_i && !por_done_reg;
		end
	end

	// count how long a cpu reset has been held
	always_ff @(posedge clk_i) begin
		if (rst_i || !cpu_reset_i) begin
			crst_cnt_reg <= '0;
		end else if (!crst_hit) begin
			crst_cnt_reg <= crst_cnt_reg + 1'b1;
		end
	end

	assign crst_hit = (crst_cnt_reg == CNT_W'(flash_mode_pkg::CPU_RST_CYCLES));

	// ************************************************************
	// command sequence decoder
	// ************************************************************
	// address, command byte and current step select the next step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_reg       <= flash_mode_pkg::SEQ_READ;
			start_reg     <= 1'b0;
			op_erase_reg  <= 1'b0;
			suspend_reg   <= 1'b0;
			prog_data_reg <= '0;
			arr_wdata_o   <= '0;
			prot_reg      <= flash_mode_pkg::PROT_RESET;
		end else begin
			start_reg <= 1'b0;
			if (crst_hit) begin
				seq_reg <= flash_mode_pkg::SEQ_READ;
			end else if (fire_wr && flash_hit) begin
				if (prot_reg[flash_mode_pkg::PROT_READ_BIT]) begin
					seq_reg <= flash_mode_pkg::SEQ_READ;
				end else if (ep.active) begin
					// only suspend and resume reach a running erase
					if (op_erase_reg && cmd == flash_mode_pkg::CMD_SUSPEND) begin
						suspend_reg <= 1'b1;
					end else if (suspend_reg && cmd == flash_mode_pkg::CMD_RESUME) begin
						suspend_reg <= 1'b0;
					end // others refused
				end else if (cmd == flash_mode_pkg::CMD_READ_RST) begin
					seq_reg <= flash_mode_pkg::SEQ_READ;
				end else begin
					seq_reg <= flash_mode_pkg::SEQ_READ; // any mismatch aborts
					case (seq_reg)
						flash_mode_pkg::SEQ_READ: begin
							if (adr_word[17:0] == flash_mode_pkg::CMD_ADDR1
								&& cmd == flash_mode_pkg::CMD_UNLOCK1) begin
								seq_reg <= flash_mode_pkg::SEQ_UNLOCK2;
							end
						end
						flash_mode_pkg::SEQ_UNLOCK2: begin
							if (adr_word[17:0] == flash_mode_pkg::CMD_ADDR2
								&& cmd == flash_mode_pkg::CMD_UNLOCK2) begin
								seq_reg <= flash_mode_pkg::SEQ_CMD;
							end
						end
						flash_mode_pkg::SEQ_CMD: begin
							if (adr_word[17:0] == flash_mode_pkg::CMD_ADDR1) begin
								if (cmd == flash_mode_pkg::CMD_PROGRAM) begin
									seq_reg <= flash_mode_pkg::SEQ_PROG_DATA;
								end else if (cmd == flash_mode_pkg::CMD_ERASE) begin
									seq_reg <= flash_mode_pkg::SEQ_ERASE_U1;
								end else if (cmd == flash_mode_pkg::CMD_PROTECT) begin
									seq_reg <= flash_mode_pkg::SEQ_PROT_BLOCK;
								end
							end
						end
						flash_mode_pkg::SEQ_PROG_DATA: begin
							if (!wr_blocked) begin
								start_reg     <= 1'b1;
								op_erase_reg  <= 1'b0;
								prog_data_reg <= wb_dat_i;
								arr_wdata_o   <= wb_dat_i;
							end
						end
						flash_mode_pkg::SEQ_ERASE_U1: begin
							if (adr_word[17:0] == flash_mode_pkg::CMD_ADDR1
								&& cmd == flash_mode_pkg::CMD_UNLOCK1) begin
								seq_reg <= flash_mode_pkg::SEQ_ERASE_U2;
							end
						end
						flash_mode_pkg::SEQ_ERASE_U2: begin
							if (adr_word[17:0] == flash_mode_pkg::CMD_ADDR2
								&& cmd == flash_mode_pkg::CMD_UNLOCK2) begin
								seq_reg <= flash_mode_pkg::SEQ_ERASE_BLOCK;
							end
						end
						flash_mode_pkg::SEQ_ERASE_BLOCK: begin
							if (cmd == flash_mode_pkg::CMD_ERASE_GO && !wr_blocked) begin
								start_reg    <= 1'b1;
								op_erase_reg <= 1'b1;
							end
						end
						flash_mode_pkg::SEQ_PROT_BLOCK: begin
							if (cmd == flash_mode_pkg::CMD_PROT_SET) begin
								prot_reg[segment_of(wb_adr_i)] <= 1'b1;
							end else if (cmd == flash_mode_pkg::CMD_PROT_CLR) begin
								prot_reg[segment_of(wb_adr_i)] <= 1'b0;
							end
						end
						default: seq_reg <= flash_mode_pkg::SEQ_READ;
					endcase
				end
			end else if (fire_wr && adr_word == flash_mode_pkg::REG_PROT_ADDR && wb_sel_i[0]) begin
				prot_reg <= wb_dat_i[5:0];
			end
			if (ep.done) begin
				suspend_reg <= 1'b0; // back to read mode after completion
			end
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	// failure is sticky until read/reset; a new failure wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_reg <= 1'b0;
		end else if (ep.done && ep.fail) begin
			fail_reg <= 1'b1;
		end else if (fire_wr && flash_hit && !ep.active
			&& cmd == flash_mode_pkg::CMD_READ_RST) begin
			fail_reg <= 1'b0;
		end
	end

	// toggle1 flips on every flash status read while an operation is active, suspended erase included, toggle2 only while erasing
	always_ff @(posedge clk_i) begin
		if (rst_i || start_reg) begin
			toggle1_reg <= 1'b0;
			toggle2_reg <= 1'b0;
		end else if (fire_rd && flash_hit && ep.active) begin
			toggle1_reg <= !toggle1_reg;
			toggle2_reg <= toggle2_reg ^ op_erase_reg;
		end
	end

	// assemble the polled status byte, reserved bits zero
	always_comb begin
		status_byte = 8'h00;
		if (op_erase_reg) begin
			status_byte[flash_mode_pkg::ST_DATA_POLL] = ep.suspended;
		end else begin
			status_byte[flash_mode_pkg::ST_DATA_POLL] = !prog_data_reg[7];
		end
		status_byte[flash_mode_pkg::ST_TOGGLE1]   = toggle1_reg;
		status_byte[flash_mode_pkg::ST_FAILURE]   = fail_reg;
		status_byte[flash_mode_pkg::ST_ERASE_WIN] = !ep.window_open;
		status_byte[flash_mode_pkg::ST_TOGGLE2]   = toggle2_reg;
	end

	// ************************************************************
	// array address and read data
	// ************************************************************
	// latch aligned word address when a flash access is taken outside status mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arr_addr_o <= '0;
		end else if (bus_take && in_flash(wb_adr_i) && !status_mode) begin
			arr_addr_o <= wb_adr_i[17:2];
		end
	end

	// read mux: array, status word or registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (fire_rd) begin
			if (flash_hit) begin
				wb_dat_o <= status_mode ? {24'h000000, status_byte} : arr_rdata_i;
			end else if (adr_word == flash_mode_pkg::REG_STATUS_ADDR) begin
				wb_dat_o <= {24'h000000, status_byte};
			end else if (adr_word == flash_mode_pkg::REG_IRQ_ADDR) begin
				wb_dat_o <= {29'h00000000, ready_busy_o, irq_en_reg, irq_req_reg};
			end else if (adr_word == flash_mode_pkg::REG_PROT_ADDR) begin
				wb_dat_o <= {26'h0000000, prot_reg};
			end else begin
				wb_dat_o <= '0;
			end
		end
	end

	// ************************************************************
	// ready/busy line and its request node
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_busy_o <= 1'b0;
			rb_prev_reg  <= 1'b0;
		end else begin
			ready_busy_o <= ep.rb;
			rb_prev_reg  <= ready_busy_o;
		end
	end

	// request set on busy-to-ready, write one clears, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_reg <= 1'b0;
			irq_en_reg  <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			if (rb_prev_reg && !ready_busy_o) begin
				irq_req_reg <= 1'b1;
			end else if (fire_wr && adr_word == flash_mode_pkg::REG_IRQ_ADDR
				&& wb_sel_i[0] && wb_dat_i[flash_mode_pkg::IRQ_REQ_BIT]) begin
				irq_req_reg <= 1'b0;
			end
			if (fire_wr && adr_word == flash_mode_pkg::REG_IRQ_ADDR && wb_sel_i[0]) begin
				irq_en_reg <= wb_dat_i[flash_mode_pkg::IRQ_EN_BIT];
			end
			irq_o <= irq_req_reg && irq_en_reg;
		end
	end

endmodule

// [verification/flash_mode_chk.sv]
`timescale 1ns/1ps
module flash_mode_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [19:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        external_access_pin_i,
	input wire logic [15:0] arr_addr_o,
	input wire logic        arr_prog_o,
	input wire logic        ready_busy_o,
	input wire logic        cpu_reset_hold_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ************************************************************
	// cycles since reset release
	// ************************************************************
	logic [8:0] up_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			up_reg <= 9'h000;
		else if (up_reg != 9'h1FF)
			up_reg <= up_reg + 9'h001;
	end
	// ************************************************************
	// properties
	// ************************************************************
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_setup; int'(up_reg) < flash_mode_pkg::SETUP_CYCLES |-> !wb_ack_o; endproperty
	a_setup: assert property (p_setup) else $error("access served in setup");
	property p_hold;
		up_reg > 9'h002 && int'(up_reg) < flash_mode_pkg::SETUP_CYCLES - 2
			|-> cpu_reset_hold_o == external_access_pin_i;
	endproperty
	a_hold: assert property (p_hold) else $error("cpu hold wrong in setup");
	property p_word;
		wb_ack_o && !wb_we_i && wb_adr_i < 20'h40000 |-> arr_addr_o == wb_adr_i[17:2];
	endproperty
	a_word: assert property (p_word) else $error("array word address wrong");
	property p_stat;
		wb_ack_o && !wb_we_i && (wb_adr_i == flash_mode_pkg::REG_STATUS_ADDR
			|| (ready_busy_o && $past(ready_busy_o) && wb_adr_i < 20'h40000))
			|-> (wb_dat_o & 32'hFFFFFF13) == 32'h00000000;
	endproperty
	a_stat: assert property (p_stat) else $error("reserved status bit set");
	property p_busy; $rose(arr_prog_o) |-> ##[0:2] ready_busy_o; endproperty
	a_busy: assert property (p_busy) else $error("busy low while programming");
	property p_rb_start;
		$rose(ready_busy_o) |-> $past(wb_ack_o, 1) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
	endproperty
	a_rb_start: assert property (p_rb_start) else $error("busy without command");
	property p_reset; $fell(rst_i) |-> !ready_busy_o && !arr_prog_o; endproperty
	a_reset: assert property (p_reset) else $error("not in read mode after reset");
endmodule
bind flash_mode_ctrl flash_mode_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .external_access_pin_i(external_access_pin_i),
	.arr_addr_o(arr_addr_o), .arr_prog_o(arr_prog_o), .ready_busy_o(ready_busy_o),
	.cpu_reset_hold_o(cpu_reset_hold_o));

// [verification/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model #(parameter int DLY = 20) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        prog_i,
	input  wire logic        erase_i,
	input  wire logic        fail_en_i,
	output logic      [31:0] rdata_o,
	output logic             done_o,
	output logic             fail_o
);
	bit [31:0] mem [0:65535];
	bit        vld [0:65535];
	int        cnt;
	// programmed words, else a pattern from the address
	assign rdata_o = vld[addr_i] ? mem[addr_i] : {addr_i, ~addr_i};
	// operation lasts DLY cycles, done holds until it is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i || !(prog_i || erase_i))
			cnt <= 0;
		else if (cnt < DLY)
			cnt <= cnt + 1;
		if (prog_i && cnt == DLY - 1 && !fail_en_i) begin
			mem[addr_i] <= wdata_i;
			vld[addr_i] <= 1'b1;
		end
	end
	assign done_o = (cnt == DLY);
	assign fail_o = fail_en_i && done_o;
endmodule

// [verification/embedded_flash_mode_controller_tb.sv]
`timescale 1ns/1ps
module embedded_flash_mode_controller_tb;
	localparam logic [19:0] C1 = {2'h0, flash_mode_pkg::CMD_ADDR1};
	localparam logic [19:0] C2 = {2'h0, flash_mode_pkg::CMD_ADDR2};
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fail_en, ext, crst;
	logic        arr_done_i, arr_fail_i, arr_prog_o, arr_erase_o, ready_busy_o, irq_o, hold;
	logic [19:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, arr_rdata_i, arr_wdata_o, q, q2;
	logic [15:0] arr_addr_o;
	int          bad_count, cmp_count;
	flash_mode_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_reset_i(crst),
		.external_access_pin_i(ext), .arr_rdata_i(arr_rdata_i), .arr_done_i(arr_done_i),
		.arr_fail_i(arr_fail_i), .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
		.arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o), .ready_busy_o(ready_busy_o),
		.irq_o(irq_o), .cpu_reset_hold_o(hold));
	flash_array_model ARR (.clk_i(clk_i), .rst_i(rst_i), .addr_i(arr_addr_o),
		.wdata_i(arr_wdata_o), .prog_i(arr_prog_o), .erase_i(arr_erase_o), .fail_en_i(fail_en),
		.rdata_o(arr_rdata_i), .done_o(arr_done_i), .fail_o(arr_fail_i));
	always #12.5 clk_i = ~clk_i;
	// ************************************************************
	// bus and check tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic we, input logic [19:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic unl;
		bus(1'b1, C1, 32'hAA);
		bus(1'b1, C2, 32'h55);
	endtask
	task automatic wait_rb(input logic lvl);
		while (ready_busy_o !== lvl) begin
			@(posedge clk_i);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ************************************************************
	// watchdog and test sequence
	// ************************************************************
	initial begin
		#(25.0 * 20000);
		bad_count++;
		conclude;
	end
	initial begin
		{clk_i, wb_cyc_i, wb_stb_i, wb_we_i, fail_en, crst} = 6'h00;
		ext = 1'b1;
		{wb_adr_i, wb_dat_i, bad_count, cmp_count} = 0;
		wb_sel_i = 4'hF;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (50) @(posedge clk_i);
		chk("hold", 32'(hold), 32'h1);
		bus(1'b0, 20'h00016, 32'h0);
		chk("read", q, 32'h0005FFFA);
		chk("hold", 32'(hold), 32'h0);
		bus(1'b0, 20'h3000C, 32'h0);
		chk("segment", q, 32'hC0033FFC);
		bus(1'b0, 20'h40010, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b0, flash_mode_pkg::REG_PROT_ADDR, 32'h0);
		chk("protect", q, 32'h0);
		bus(1'b1, flash_mode_pkg::REG_IRQ_ADDR, 32'h2);
		$display("test read done");
		unl;
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h00100, 32'h12345678);
		bus(1'b0, 20'h00100, 32'h0);
		q2 = q;
		bus(1'b0, 20'h00100, 32'h0);
		chk("poll", q2 & 32'h80, 32'h80);
		chk("reserved", q2 & 32'hFFFFFF13, 32'h0);
		chk("toggle", (q ^ q2) & 32'h40, 32'h40);
		chk("busy", 32'(ready_busy_o), 32'h1);
		unl;
		wait_rb(1'b0);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq_o), 32'h1);
		bus(1'b0, 20'h00100, 32'h0);
		chk("programmed", q, 32'h12345678);
		bus(1'b1, flash_mode_pkg::REG_IRQ_ADDR, 32'h3);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'(irq_o), 32'h0);
		$display("test program done");
		bus(1'b1, C1, 32'hAA);
		bus(1'b1, C2, 32'h11);
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h00104, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("abort", 32'(ready_busy_o), 32'h0);
		bus(1'b0, 20'h00104, 32'h0);
		chk("abort", q, 32'h0041FFBE);
		$display("test abort done");
		unl;
		bus(1'b1, C1, 32'h80);
		unl;
		bus(1'b1, 20'h10000, 32'h30);
		bus(1'b0, 20'h10000, 32'h0);
		chk("window", q & 32'h88, 32'h0);
		wait_rb(1'b0);
		bus(1'b0, 20'h10000, 32'h0);
		chk("erased", q, 32'h4000BFFF);
		$display("test erase done");
		fail_en <= 1'b1;
		unl;
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h00108, 32'hFF);
		wait_rb(1'b1);
		wait_rb(1'b0);
		fail_en <= 1'b0;
		bus(1'b0, 20'h00108, 32'h0);
		chk("failure", q & 32'h20, 32'h20);
		bus(1'b1, C1, 32'hF0);
		bus(1'b0, 20'h00108, 32'h0);
		chk("cleared", q, 32'h0042FFBD);
		$display("test failure done");
		unl;
		bus(1'b1, C1, 32'h60);
		bus(1'b1, 20'h00000, 32'h01);
		bus(1'b0, flash_mode_pkg::REG_PROT_ADDR, 32'h0);
		chk("prot", q, 32'h1);
		unl;
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h00110, 32'h0);
		bus(1'b1, flash_mode_pkg::REG_PROT_ADDR, 32'h20);
		chk("prot", 32'(ready_busy_o), 32'h0);
		unl;
		bus(1'b1, flash_mode_pkg::REG_PROT_ADDR, 32'h0);
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h00110, 32'h0);
		bus(1'b0, 20'h00110, 32'h0);
		chk("rprot", q, 32'h0044FFBB);
		unl;
		crst <= 1'b1;
		repeat (90) @(posedge clk_i);
		crst <= 1'b0;
		bus(1'b1, C1, 32'hA0);
		bus(1'b1, 20'h0010C, 32'h0);
		bus(1'b0, 20'h0010C, 32'h0);
		chk("cpu reset", q, 32'h0043FFBC);
		$display("test protect done");
		unl;
		bus(1'b1, C1, 32'h80);
		unl;
		bus(1'b1, 20'h20000, 32'h30);
		bus(1'b1, 20'h20000, 32'hB0);
		wait_rb(1'b0);
		bus(1'b0, 20'h20000, 32'h0);
		chk("suspend", q & 32'h88, 32'h88);
		chk("suspend", 32'(arr_erase_o), 32'h0);
		bus(1'b1, 20'h20000, 32'h30);
		wait_rb(1'b1);
		wait_rb(1'b0);
		bus(1'b0, 20'h20000, 32'h0);
		chk("resume", q, 32'h80007FFF);
		$display("test suspend done");
		ext <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk("hold", 32'(hold), 32'h0);
		bus(1'b0, 20'h00100, 32'h0);
		chk("after reset", q, 32'h12345678);
		$display("test reset done");
		conclude;
	end
endmodule
